// [common/adirq_pkg.sv]
package adirq_pkg;
  // register offsets
  localparam logic [7:0] ADDR_CONTROL = 8'h02;
  localparam logic [7:0] ADDR_EVENT_LATCH = 8'h03;
  localparam logic [7:0] ADDR_EVENT_MASK = 8'h05;
  localparam logic [7:0] ADDR_ID_RESISTOR_VALUE = 8'h07;
  localparam logic [7:0] ADDR_MEAS_DURATION = 8'h08;
  localparam logic [7:0] ADDR_LIVE_CONDITION = 8'h09;

  // reset values
  localparam logic [7:0] RST_EVENT_MASK = 8'h00;
  localparam logic [7:0] RST_MEAS_DURATION = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'hD1;
  localparam logic [7:0] RST_READ = 8'h00;

  // event, mask and status bit positions
  localparam int BIT_OVERCURRENT = 6;
  localparam int BIT_OVERVOLTAGE = 5;
  localparam int BIT_MIC_OVERVOLTAGE = 4;
  localparam int BIT_RESISTOR_CODE = 3;
  localparam int BIT_BUS_VALID = 2;
  localparam int BIT_CHARGE_DONE = 1;
  localparam logic [7:0] EVENT_USED = 8'h7E;

  // status-only bits
  localparam int BIT_ID_SHORTED = 7;
  localparam int BIT_ID_NOT_FLOATING = 3;
  localparam int BIT_CHARGE_ACTIVE = 1;
  localparam int BIT_DATA_CONTACT = 0;

  // control fields
  localparam int BIT_CONTACT_TIMEOUT_EN = 7;
  localparam int BIT_ID_DETECT_DISABLE = 5;
  localparam int BIT_GLOBAL_MASK = 0;
  localparam logic [7:0] CONTROL_USED = 8'hB1;

  localparam int CODE_W = 5;
  localparam int TIME_W = 4;

  // measurement timing
  localparam int CLK_HZ = 25_000_000;
  localparam int MEAS_STEP_MS = 50;
  localparam int CYCLES_PER_MS = CLK_HZ / 1000;
  localparam int MEAS_STEP_CYC = MEAS_STEP_MS * CYCLES_PER_MS;
  localparam logic [3:0] MEAS_FINE_LAST = 4'h3;
  localparam logic [3:0] MEAS_CODE_LAST = 4'hB;
  localparam logic [4:0] MEAS_COARSE_BASE = 5'h06;
  localparam logic [4:0] MEAS_COARSE_OFS = 5'h04;
endpackage

// [src/adirq_change_det.sv]
`timescale 1ns/1ps
`default_nettype none
// flags a change of a value between consecutive cycles
module adirq_change_det #(
  parameter int W = 1
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] value_i,
  output logic changed_o
);
  logic [W-1:0] last;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last <= '0;
    end else begin
      last <= value_i;
    end
  end

  assign changed_o = (last != value_i);
endmodule
`default_nettype wire

// [src/adirq_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for pin-side levels
module adirq_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] stage1;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule
`default_nettype wire

// [src/adirq_regs.sv]
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Overcurrent flag change sets event bit 6.
// - Bus overvoltage flag change sets event bit 5.
// - Mic overvoltage flag change sets event bit 4.
// - Resistor code change sets event bit 3.
// - No resistor code event while ID detect disable is one.
// - Code going nonzero to zero (floating contact) raises the code event.
// - Charger detection completion sets event bit 1.
// - Mask bits 6..1 suppress matching interrupts; reset to zero.
// - Five-bit resistor code readable in bits 4:0, upper bits zero.
// - Timing field sets measurement time: 50..200 ms, then 300..1000 ms.
// - Status bit 7 shows Id_shorted_flag.
// - Status bit 6 shows overcurrent.
// - Status bit 5 shows bus overvoltage.
// - Status bit 4 shows mic overvoltage.
// - Status bit 3 shows resistor present on ID contact.
// - Status bit 1 shows charger detection active.
// - Status bit 0 shows data contact on last detect sequence.
// - Global mask bit in control blocks the host interrupt.
// - ID detect disable stops measuring once a resistor is found.
module adirq_regs (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic overcurrent_flag_i,
  input wire logic overvoltage_flag_i,
  input wire logic mic_overvoltage_flag_i,
  input wire logic id_shorted_flag_i,
  input wire logic bus_valid_i,
  input wire logic charge_active_i,
  input wire logic charge_done_i,
  input wire logic data_contact_detected_i,
  input wire logic [4:0] id_code_meas_i,
  output logic meas_window_o,
  output logic meas_done_o,
  output logic id_detect_disable_o,
  output logic contact_timeout_enable_o,
  output logic host_irq_o
);
  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  localparam int SYNC_W = 13;
  logic [SYNC_W-1:0] pin_sync;
  logic oc_s, ov_s, mov_s, short_s, bvalid_s, cact_s, cdone_s, dcd_s;
  logic [4:0] code_s;
  logic cdone_last;

  adirq_sync #(.W(SYNC_W)) u_sync (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .async_i({overcurrent_flag_i, overvoltage_flag_i, mic_overvoltage_flag_i,
      id_shorted_flag_i, bus_valid_i, charge_active_i, charge_done_i,
      data_contact_detected_i, id_code_meas_i}),
    .sync_o(pin_sync)
  );

  assign {oc_s, ov_s, mov_s, short_s, bvalid_s, cact_s, cdone_s, dcd_s, code_s} = pin_sync;

  //////////////////////////////////////////////////////////////////////////////
  // control and software registers
  logic [7:0] control;
  logic [7:0] event_mask;
  logic [7:0] measurement_duration;
  logic [7:0] event_latch;
  logic [4:0] id_resistor_value;
  logic code_locked;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      control <= adirq_pkg::RST_CONTROL & adirq_pkg::CONTROL_USED;
    end else if (reg_wr_i && reg_addr_i == adirq_pkg::ADDR_CONTROL) begin
      control <= reg_wdata_i & adirq_pkg::CONTROL_USED;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      event_mask <= adirq_pkg::RST_EVENT_MASK;
    end else if (reg_wr_i && reg_addr_i == adirq_pkg::ADDR_EVENT_MASK) begin
      event_mask <= reg_wdata_i & adirq_pkg::EVENT_USED;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      measurement_duration <= adirq_pkg::RST_MEAS_DURATION;
    end else if (reg_wr_i && reg_addr_i == adirq_pkg::ADDR_MEAS_DURATION) begin
      measurement_duration <= {4'h0, reg_wdata_i[adirq_pkg::TIME_W-1:0]};
    end
  end

  assign id_detect_disable_o = control[adirq_pkg::BIT_ID_DETECT_DISABLE];
  assign contact_timeout_enable_o = control[adirq_pkg::BIT_CONTACT_TIMEOUT_EN];

  //////////////////////////////////////////////////////////////////////////////
  // measurement timer
  logic [3:0] time_code;
  logic [4:0] steps_total;
  logic [4:0] step_cnt;
  logic [20:0] cyc_cnt;
  logic step_tick;

  assign time_code = measurement_duration[3:0];

  // codes up to 3 step by 50 ms, up to 11 by 100 ms (two 50 ms steps), codes above 11 hold at 1000 ms
  always_comb begin
    if (time_code <= adirq_pkg::MEAS_FINE_LAST) begin
      steps_total = {1'b0, time_code} + 5'h01;
    end else if (time_code <= adirq_pkg::MEAS_CODE_LAST) begin
      steps_total = adirq_pkg::MEAS_COARSE_BASE
        + 5'(({1'b0, time_code} - adirq_pkg::MEAS_COARSE_OFS) << 1);
    end else begin
      steps_total = 5'(({1'b0, adirq_pkg::MEAS_CODE_LAST} - adirq_pkg::MEAS_COARSE_OFS) << 1)
        + adirq_pkg::MEAS_COARSE_BASE;
    end
  end

  assign step_tick = (cyc_cnt == 21'(adirq_pkg::MEAS_STEP_CYC - 1));

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cyc_cnt <= '0;
    end else if (!meas_window_o || step_tick) begin
      cyc_cnt <= '0;
    end else begin
      cyc_cnt <= cyc_cnt + 21'h000001;
    end
  end

  // window restarts on each completed measurement unless locked
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      step_cnt <= '0;
      meas_done_o <= 1'b0;
    end else begin
      meas_done_o <= 1'b0;
      if (!meas_window_o) begin
        step_cnt <= '0;
      end else if (step_tick) begin
        if (step_cnt + 5'h01 >= steps_total) begin
          step_cnt <= '0;
          meas_done_o <= 1'b1;
        end else begin
          step_cnt <= step_cnt + 5'h01;
        end
      end
    end
  end

  // a found resistor stops detection while disable is set; floating is still watched
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      code_locked <= 1'b0;
    end else if (!id_detect_disable_o || code_s == '0) begin
      code_locked <= 1'b0;
    end else if (meas_done_o && id_resistor_value != '0) begin
      code_locked <= 1'b1;
    end
  end

  assign meas_window_o = !code_locked;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      id_resistor_value <= '0;
    end else if (code_s == '0) begin
      id_resistor_value <= '0;
    end else if (meas_done_o && !code_locked) begin
      id_resistor_value <= code_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // change detection and event latch
  logic [3:0] level_chg;
  logic code_chg;
  logic [7:0] event_set;
  logic rd_latch;

  for (genvar g = 0; g < 4; g++) begin : g_chg
    adirq_change_det #(.W(1)) u_chg (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .value_i(g == 0 ? bvalid_s : g == 1 ? mov_s : g == 2 ? ov_s : oc_s),
      .changed_o(level_chg[g])
    );
  end

  adirq_change_det #(.W(adirq_pkg::CODE_W)) u_code_chg (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .value_i(id_resistor_value),
    .changed_o(code_chg)
  );

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cdone_last <= 1'b0;
    end else begin
      cdone_last <= cdone_s;
    end
  end

  always_comb begin
    event_set = 8'h00;
    event_set[adirq_pkg::BIT_OVERCURRENT] = level_chg[3];
    event_set[adirq_pkg::BIT_OVERVOLTAGE] = level_chg[2];
    event_set[adirq_pkg::BIT_MIC_OVERVOLTAGE] = level_chg[1];
    event_set[adirq_pkg::BIT_RESISTOR_CODE] = code_chg && !id_detect_disable_o;
    event_set[adirq_pkg::BIT_BUS_VALID] = level_chg[0];
    event_set[adirq_pkg::BIT_CHARGE_DONE] = cdone_s && !cdone_last;
  end

  assign rd_latch = reg_rd_i && reg_addr_i == adirq_pkg::ADDR_EVENT_LATCH;

  // set wins over the read clear
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      event_latch <= 8'h00;
    end else if (rd_latch) begin
      event_latch <= event_set & adirq_pkg::EVENT_USED;
    end else begin
      event_latch <= (event_latch | event_set) & adirq_pkg::EVENT_USED;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      host_irq_o <= 1'b0;
    end else begin
      host_irq_o <= |(event_latch & ~event_mask)
        && !control[adirq_pkg::BIT_GLOBAL_MASK];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status and read port
  logic [7:0] live_condition;
  logic [7:0] next_rdata;

  always_comb begin
    live_condition = 8'h00;
    live_condition[adirq_pkg::BIT_ID_SHORTED] = short_s;
    live_condition[adirq_pkg::BIT_OVERCURRENT] = oc_s;
    live_condition[adirq_pkg::BIT_OVERVOLTAGE] = ov_s;
    live_condition[adirq_pkg::BIT_MIC_OVERVOLTAGE] = mov_s;
    live_condition[adirq_pkg::BIT_ID_NOT_FLOATING] = (id_resistor_value != '0);
    live_condition[adirq_pkg::BIT_BUS_VALID] = bvalid_s;
    live_condition[adirq_pkg::BIT_CHARGE_ACTIVE] = cact_s;
    live_condition[adirq_pkg::BIT_DATA_CONTACT] = dcd_s;
  end

  always_comb begin
    case (reg_addr_i)
      adirq_pkg::ADDR_CONTROL: next_rdata = control;
      adirq_pkg::ADDR_EVENT_LATCH: next_rdata = event_latch;
      adirq_pkg::ADDR_EVENT_MASK: next_rdata = event_mask;
      adirq_pkg::ADDR_ID_RESISTOR_VALUE: next_rdata = {3'h0, id_resistor_value};
      adirq_pkg::ADDR_MEAS_DURATION: next_rdata = measurement_duration;
      adirq_pkg::ADDR_LIVE_CONDITION: next_rdata = live_condition;
      default: next_rdata = adirq_pkg::RST_READ;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= adirq_pkg::RST_READ;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  chk_oc_event_set: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $changed(oc_s) |=> event_latch[adirq_pkg::BIT_OVERCURRENT])
    else $error("overcurrent change not latched");

  chk_ov_event_set: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $changed(ov_s) |=> event_latch[adirq_pkg::BIT_OVERVOLTAGE])
    else $error("overvoltage change not latched");

  chk_mic_event_set: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $changed(mov_s) |=> event_latch[adirq_pkg::BIT_MIC_OVERVOLTAGE])
    else $error("mic overvoltage change not latched");

  chk_code_event_gate: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $changed(id_resistor_value) && !id_detect_disable_o |=> event_latch[3])
    else $error("code change not latched");

  chk_code_disabled: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !event_latch[3] && !rd_latch && id_detect_disable_o && $stable(id_detect_disable_o)
      |=> !event_latch[3])
    else $error("code event raised while disabled");

  chk_read_clears: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    rd_latch && event_set == 8'h00 |=> event_latch == 8'h00 && reg_rdata_o == $past(event_latch))
    else $error("event read did not clear");

  chk_irq_global_mask: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    control[adirq_pkg::BIT_GLOBAL_MASK] |=> !host_irq_o)
    else $error("irq raised while globally masked");

  chk_irq_raise: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    |(event_latch & ~event_mask) && !control[0] |=> host_irq_o)
    else $error("unmasked event did not interrupt");

  chk_status_read: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    reg_rd_i && reg_addr_i == adirq_pkg::ADDR_LIVE_CONDITION |=> reg_rdata_o[6] == $past(oc_s))
    else $error("status overcurrent mismatch");

  sequence seq_charge_rise;
    !cdone_s ##1 cdone_s;
  endsequence

  chk_done_event_set: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    seq_charge_rise |=> event_latch[adirq_pkg::BIT_CHARGE_DONE])
    else $error("charger detection completion not latched");

  chk_bvalid_event_set: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $changed(bvalid_s) |=> event_latch[adirq_pkg::BIT_BUS_VALID])
    else $error("bus-valid change not latched");

  // found code, then the contact floats while the event is allowed
  sequence seq_code_float;
    id_resistor_value != '0 && code_s == '0 ##1 !id_detect_disable_o;
  endsequence

  chk_code_float_event: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    seq_code_float |=> event_latch[adirq_pkg::BIT_RESISTOR_CODE])
    else $error("floating contact did not raise code event");

  chk_lock_stops_window: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    id_detect_disable_o && meas_done_o && id_resistor_value != '0 && code_s != '0
      |=> !meas_window_o)
    else $error("measurement kept running after resistor found");

  chk_code_read: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    reg_rd_i && reg_addr_i == adirq_pkg::ADDR_ID_RESISTOR_VALUE
      |=> reg_rdata_o == {3'h0, $past(id_resistor_value)})
    else $error("resistor code read mismatch");
endmodule
`default_nettype wire

// [dv/adirq_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// register-bus master standing in for the baseband processor
module adirq_host_model (
  input wire logic clk_sys_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    d = data;
    if (addr === adirq_pkg::ADDR_MEAS_DURATION && d[3:0] > adirq_pkg::MEAS_CODE_LAST) begin
      d[3:0] = adirq_pkg::MEAS_CODE_LAST;
    end
    @(posedge clk_sys_i);
    reg_addr_o <= addr;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
    // released lines show the complement of the last value, not the last value
    reg_addr_o <= ~addr;
    reg_wdata_o <= ~d;
  endtask

  task automatic read_reg(input logic [7:0] addr);
    @(posedge clk_sys_i);
    reg_addr_o <= addr;
    reg_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~addr;
  endtask
endmodule
`default_nettype wire

// [dv/tb_accessory_detect_irq_status_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_accessory_detect_irq_status_regs;
  logic clk_sys_i;
  logic reset_n_i;
  logic [7:0] pins;
  logic charge_done;
  logic [4:0] id_code;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic id_detect_disable;
  logic tmo_en;
  logic host_irq;
  logic meas_window;
  logic meas_done;
  logic rd_seen;
  logic [7:0] exp_q[$];
  logic [7:0] care_q[$];
  int miscompares;
  int compares;
  int cycles;
  logic [7:0] r;

  adirq_host_model adirq_host_model_inst (
    .clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd)
  );

  adirq_regs adirq_regs_inst (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .overcurrent_flag_i(pins[6]), .overvoltage_flag_i(pins[5]),
    .mic_overvoltage_flag_i(pins[4]), .id_shorted_flag_i(pins[7]), .bus_valid_i(pins[2]),
    .charge_active_i(pins[1]), .charge_done_i(charge_done),
    .data_contact_detected_i(pins[0]), .id_code_meas_i(id_code), .meas_window_o(meas_window),
    .meas_done_o(meas_done), .id_detect_disable_o(id_detect_disable), .contact_timeout_enable_o(tmo_en),
    .host_irq_o(host_irq)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (miscompares == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got,
                          input logic [7:0] care);
    compares++;
    if ((got & care) !== (exp & care)) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic expect_read(input logic [7:0] addr, input logic [7:0] exp,
                             input logic [7:0] care);
    exp_q.push_back(exp);
    care_q.push_back(care);
    adirq_host_model_inst.read_reg(addr);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic set_pin(input int b, input logic v);
    @(posedge clk_sys_i);
    pins[b] <= v;
    idle(6);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // read data is checked only in the cycle after the strobe
  always @(posedge clk_sys_i) rd_seen <= reg_rd;

  always @(negedge clk_sys_i) begin
    if (rd_seen === 1'b1) begin
      if (exp_q.size() == 0) begin
        miscompares++;
        $display("wrong value read_data expected none seen %h", reg_rdata);
      end else begin
        chk_byte("read_data", exp_q.pop_front(), reg_rdata, care_q.pop_front());
      end
    end
  end

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles >= 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n_i = 1'b0;
    pins = 8'h00;
    charge_done = 1'b0;
    id_code = 5'h00;
    miscompares = 0;
    compares = 0;
    r = 8'h00;
    void'($urandom(32'hA9DF));
    idle(4);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    id_code <= 5'($urandom_range(31, 1));
    expect_read(adirq_pkg::ADDR_EVENT_LATCH, 8'h00, 8'hFF);
    expect_read(adirq_pkg::ADDR_EVENT_MASK, 8'h00, 8'hFF);
    expect_read(adirq_pkg::ADDR_ID_RESISTOR_VALUE, 8'h00, 8'hFF);
    expect_read(adirq_pkg::ADDR_MEAS_DURATION, 8'h00, 8'hFF);
    expect_read(adirq_pkg::ADDR_LIVE_CONDITION, 8'h00, 8'hFF);
    expect_read(adirq_pkg::ADDR_CONTROL,
                adirq_pkg::RST_CONTROL & adirq_pkg::CONTROL_USED, 8'hFF);
    expect_read(8'h0A, 8'h00, 8'hFF);
    chk_bit("meas_window", 1'b1, meas_window);
    chk_bit("host_irq", 1'b0, host_irq);
    // read-only places ignore writes
    adirq_host_model_inst.write_reg(adirq_pkg::ADDR_EVENT_LATCH, 8'hFF);
    adirq_host_model_inst.write_reg(adirq_pkg::ADDR_ID_RESISTOR_VALUE, 8'hFF);
    adirq_host_model_inst.write_reg(adirq_pkg::ADDR_LIVE_CONDITION, 8'hFF);
    expect_read(adirq_pkg::ADDR_EVENT_LATCH, 8'h00, 8'hFF);
    expect_read(adirq_pkg::ADDR_ID_RESISTOR_VALUE, 8'h00, 8'hFF);
    expect_read(adirq_pkg::ADDR_LIVE_CONDITION, 8'h00, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      r = 8'($urandom());
      adirq_host_model_inst.write_reg(adirq_pkg::ADDR_EVENT_MASK, r);
      expect_read(adirq_pkg::ADDR_EVENT_MASK, r & adirq_pkg::EVENT_USED, 8'hFF);
      r = 8'($urandom_range(11, 0));
      adirq_host_model_inst.write_reg(adirq_pkg::ADDR_MEAS_DURATION, r);
      expect_read(adirq_pkg::ADDR_MEAS_DURATION, r, 8'hFF);
    end
    adirq_host_model_inst.write_reg(adirq_pkg::ADDR_EVENT_MASK, 8'h00);
    // each pin-driven live level, and its change event in both directions
    foreach (pins[b]) begin
      if (b != 3) begin
        r = (b == 6 || b == 5 || b == 4 || b == 2) ? 8'(1 << b) : 8'h00;
        set_pin(b, 1'b1);
        expect_read(adirq_pkg::ADDR_LIVE_CONDITION, 8'(1 << b), 8'hFF);
        expect_read(adirq_pkg::ADDR_EVENT_LATCH, r, 8'hFF);
        expect_read(adirq_pkg::ADDR_EVENT_LATCH, 8'h00, 8'hFF);
        set_pin(b, 1'b0);
        expect_read(adirq_pkg::ADDR_EVENT_LATCH, r, 8'hFF);
      end
    end
    @(posedge clk_sys_i);
    charge_done <= 1'b1;
    idle(6);
    expect_read(adirq_pkg::ADDR_EVENT_LATCH, 8'h02, 8'hFF);
    @(posedge clk_sys_i);
    charge_done <= 1'b0;
    idle(6);
    expect_read(adirq_pkg::ADDR_EVENT_LATCH, 8'h00, 8'hFF);
    // host interrupt: global and per-bit masking
    adirq_host_model_inst.write_reg(adirq_pkg::ADDR_CONTROL, 8'h80);
    idle(1);
    chk_bit("timeout_enable", 1'b1, tmo_en);
    chk_bit("id_disable", 1'b0, id_detect_disable);
    set_pin(6, 1'b1);
    chk_bit("host_irq", 1'b1, host_irq);
    expect_read(adirq_pkg::ADDR_EVENT_LATCH, 8'h40, 8'hFF);
    idle(2);
    chk_bit("host_irq", 1'b0, host_irq);
    adirq_host_model_inst.write_reg(adirq_pkg::ADDR_EVENT_MASK, 8'h40);
    set_pin(6, 1'b0);
    chk_bit("host_irq", 1'b0, host_irq);
    expect_read(adirq_pkg::ADDR_EVENT_LATCH, 8'h40, 8'hFF);
    set_pin(2, 1'b1);
    chk_bit("host_irq", 1'b1, host_irq);
    expect_read(adirq_pkg::ADDR_EVENT_LATCH, 8'h04, 8'hFF);
    adirq_host_model_inst.write_reg(adirq_pkg::ADDR_CONTROL, 8'h21);
    idle(1);
    chk_bit("timeout_enable", 1'b0, tmo_en);
    chk_bit("id_disable", 1'b1, id_detect_disable);
    set_pin(2, 1'b0);
    chk_bit("host_irq", 1'b0, host_irq);
    expect_read(adirq_pkg::ADDR_EVENT_LATCH, 8'h04, 8'hFF);
    expect_read(adirq_pkg::ADDR_CONTROL, 8'h21, 8'hFF);
    idle(3);
    chk_bit("meas_done", 1'b0, meas_done);
    report_and_stop();
  end
endmodule
`default_nettype wire
